// ==== verilog/tocu_pkg.sv ====
// Constants shared by the timer output compare unit
package tocu_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_FORCE = 8'h04;
   localparam logic [7:0] OFS_COUNT = 8'h08;
   localparam logic [7:0] OFS_CMP_A = 8'h0C;
   localparam logic [7:0] OFS_CMP_B = 8'h10;
   localparam logic [7:0] OFS_FLAGS = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   // Control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SEL_A_LSB = 4;
   localparam int CTRL_SEL_B_LSB = 6;
   // Flag register fields, also irq enable and irq vector bit order
   localparam int FLAG_OVF = 0;
   localparam int FLAG_MATCH_A = 1;
   localparam int FLAG_MATCH_B = 2;
   // Status register fields
   localparam int STAT_WAVE_A = 0;
   localparam int STAT_WAVE_B = 1;
   localparam int STAT_BOTTOM = 2;
   localparam int STAT_MAX = 3;
   // Counter extremes
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_STEP = 8'h01;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [1:0] RST_SEL = 2'h0;
   localparam logic RST_WAVE = 1'b0;
   // Waveform mode codes; odd codes are the PWM modes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_CLR_ON_MATCH = 3'h2;
   localparam int MODE_PWM_BIT = 0;
   // Output action selections
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   // Bus transfer type bits
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // Bus data phase tracker
   typedef enum logic [1:0] {
      TOCU_BUS_IDLE = 2'b00,
      TOCU_BUS_WRITE = 2'b01,
      TOCU_BUS_RD_WAIT = 2'b10,
      TOCU_BUS_RD_DONE = 2'b11
   } tocu_bus_state_type;
endpackage : tocu_pkg

// ==== verilog/tocu_top.sv ====
// Output compare unit of an 8-bit timer with AHB-Lite register access
//
// The placing of the registers and the AHB-Lite register port were left to the implementer.
module tocu_top #(
   parameter int CHANNELS = 2 // Compare channels
) (
   input wire logic clk_sys, // System clock
   input wire logic nrst, // Asynchronous reset, active low
   input wire logic timer_tick, // One-cycle timer clock from clock select
   input wire logic hsel, // AHB-Lite slave select
   input wire logic [31:0] haddr, // AHB-Lite address
   input wire logic [1:0] htrans, // AHB-Lite transfer type
   input wire logic hwrite, // AHB-Lite write
   input wire logic [2:0] hsize, // AHB-Lite size, word only
   input wire logic [31:0] hwdata, // AHB-Lite write data
   input wire logic hready, // AHB-Lite bus ready
   output logic hreadyout, // AHB-Lite slave ready
   output logic hresp, // AHB-Lite response, always OKAY
   output logic [31:0] hrdata, // AHB-Lite read data
   output logic [2:0] irq_req, // Interrupt requests, flag order
   input wire logic [2:0] irq_ack, // Interrupt serviced pulses, flag order
   input wire logic [1:0] port_value, // General port output value per pin
   input wire logic [1:0] wave_pin_direction_bit, // Port direction, 1 = output
   output logic [1:0] pin_o, // Pin output value
   output logic [1:0] pin_oe // Pin output enable
);
   // Reset synchroniser
   logic rst_meta_r; // First stage, read only by second
   logic rst_n; // Released reset for the design

   // Bus tracker
   tocu_pkg::tocu_bus_state_type bus_r; // Data phase kind
   logic [7:0] addr_r; // Latched address offset
   logic [31:0] hrdata_r; // Read data holding register
   logic addr_ok; // Address phase taken this cycle
   logic wr_go; // Write commits this cycle

   // Register state
   logic [2:0] waveform_mode_sel; // Waveform mode
   logic [1:0] output_action_sel [CHANNELS]; // Per channel output select
   logic [7:0] counter_value; // Counter
   logic [7:0] compare_value_chan [CHANNELS]; // Active compare values
   logic [7:0] compare_buf [CHANNELS]; // Buffered compare values
   logic [CHANNELS-1:0] match_flag_chan; // Compare flags
   logic overflow_flag; // Overflow flag
   logic [2:0] irq_en_r; // Interrupt enables
   logic [CHANNELS-1:0] wave_output_state; // Internal output registers
   logic block_r; // Match blocking after counter write

   // Decoded helpers
   logic pwm_mode; // Buffering active
   logic at_bottom; // Counter at bottom
   logic at_max; // Counter at max
   logic cnt_wr; // CPU writes counter
   logic [CHANNELS-1:0] cmp_eq; // Comparator outputs
   logic [CHANNELS-1:0] match_hit; // Matches that take effect
   logic [CHANNELS-1:0] force_hit; // Force strobes
   logic [CHANNELS-1:0] cmp_wr; // CPU writes compare
   logic [2:0] flag_w1c; // Flag clear by write of ones
   logic [31:0] rd_mux; // Read selection

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // Address phase qualifier; only whole words are supported
   assign addr_ok = hsel && hready && (htrans == tocu_pkg::HTRANS_NONSEQ);
   assign wr_go = (bus_r == tocu_pkg::TOCU_BUS_WRITE);

   // Bus data phase tracking; reads take one wait state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus_r <= tocu_pkg::TOCU_BUS_IDLE;
         addr_r <= tocu_pkg::RST_BYTE;
      end else begin
         unique case (bus_r)
            // Read data is sampled after any earlier write has landed
            tocu_pkg::TOCU_BUS_RD_WAIT: begin
               bus_r <= tocu_pkg::TOCU_BUS_RD_DONE;
            end
            default: begin
               // Idle, write and read-done all accept a new address
               if (addr_ok) begin
                  bus_r <= hwrite ? tocu_pkg::TOCU_BUS_WRITE : tocu_pkg::TOCU_BUS_RD_WAIT;
                  addr_r <= haddr[7:0];
               end else begin
                  bus_r <= tocu_pkg::TOCU_BUS_IDLE;
               end
            end
         endcase
      end
   end

   // Wait state only while the read data is being fetched
   assign hreadyout = (bus_r != tocu_pkg::TOCU_BUS_RD_WAIT);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Mode decode and counter extremes
   assign pwm_mode = waveform_mode_sel[tocu_pkg::MODE_PWM_BIT];
   assign at_bottom = (counter_value == tocu_pkg::CNT_BOTTOM);
   assign at_max = (counter_value == tocu_pkg::CNT_MAX);
   assign cnt_wr = wr_go && (addr_r == tocu_pkg::OFS_COUNT);
   assign flag_w1c = (wr_go && addr_r == tocu_pkg::OFS_FLAGS) ? hwdata[2:0] : 3'h0;

   // Read multiplexer; unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_r)
         tocu_pkg::OFS_CTRL: begin
            rd_mux[tocu_pkg::CTRL_MODE_LSB +: 3] = waveform_mode_sel;
            rd_mux[tocu_pkg::CTRL_SEL_A_LSB +: 2] = output_action_sel[0];
            rd_mux[tocu_pkg::CTRL_SEL_B_LSB +: 2] = output_action_sel[1];
         end
         // Strobes hold no state
         tocu_pkg::OFS_FORCE: rd_mux = 32'h0000_0000;
         tocu_pkg::OFS_COUNT: rd_mux[7:0] = counter_value;
         // Buffer while buffering, active compare otherwise
         tocu_pkg::OFS_CMP_A: rd_mux[7:0] = pwm_mode ? compare_buf[0] : compare_value_chan[0];
         tocu_pkg::OFS_CMP_B: rd_mux[7:0] = pwm_mode ? compare_buf[1] : compare_value_chan[1];
         tocu_pkg::OFS_FLAGS: begin
            rd_mux[tocu_pkg::FLAG_OVF] = overflow_flag;
            rd_mux[tocu_pkg::FLAG_MATCH_A] = match_flag_chan[0];
            rd_mux[tocu_pkg::FLAG_MATCH_B] = match_flag_chan[1];
         end
         tocu_pkg::OFS_IRQ_EN: rd_mux[2:0] = irq_en_r;
         tocu_pkg::OFS_STATUS: begin
            rd_mux[tocu_pkg::STAT_WAVE_A] = wave_output_state[0];
            rd_mux[tocu_pkg::STAT_WAVE_B] = wave_output_state[1];
            rd_mux[tocu_pkg::STAT_BOTTOM] = at_bottom;
            rd_mux[tocu_pkg::STAT_MAX] = at_max;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data captured in the wait state, held until the next read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_r <= 32'h0000_0000;
      end else if (bus_r == tocu_pkg::TOCU_BUS_RD_WAIT) begin
         hrdata_r <= rd_mux;
      end
   end

   // Control register: mode and unbuffered output selects
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         waveform_mode_sel <= tocu_pkg::RST_MODE;
         output_action_sel[0] <= tocu_pkg::RST_SEL;
         output_action_sel[1] <= tocu_pkg::RST_SEL;
      end else if (wr_go && addr_r == tocu_pkg::OFS_CTRL) begin
         waveform_mode_sel <= hwdata[tocu_pkg::CTRL_MODE_LSB +: 3];
         // Selects land at once, not with the compare buffer
         output_action_sel[0] <= hwdata[tocu_pkg::CTRL_SEL_A_LSB +: 2];
         output_action_sel[1] <= hwdata[tocu_pkg::CTRL_SEL_B_LSB +: 2];
      end
   end

   // Interrupt enable register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_en_r <= 3'h0;
      end else if (wr_go && addr_r == tocu_pkg::OFS_IRQ_EN) begin
         irq_en_r <= hwdata[2:0];
      end
   end

   // Counter; counting ignores the output selects entirely
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         counter_value <= tocu_pkg::RST_BYTE;
      end else if (cnt_wr) begin
         counter_value <= hwdata[7:0];
      end else if (timer_tick) begin
         counter_value <= 8'(counter_value + tocu_pkg::CNT_STEP);
      end
   end

   // Match blocking holds until the next timer clock is consumed
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         block_r <= 1'b0;
      end else if (cnt_wr) begin
         block_r <= 1'b1;
      end else if (timer_tick) begin
         block_r <= 1'b0;
      end
   end

   // Overflow flag; set beats any clear in the same cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         overflow_flag <= 1'b0;
      end else if (timer_tick && at_max && !cnt_wr) begin
         overflow_flag <= 1'b1;
      end else if (flag_w1c[tocu_pkg::FLAG_OVF] || irq_ack[tocu_pkg::FLAG_OVF]) begin
         overflow_flag <= 1'b0;
      end
   end

   // Per channel compare, flag and output logic
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      // Register offset and flag position of this channel
      localparam logic [7:0] OFS = (ch == 0) ? tocu_pkg::OFS_CMP_A : tocu_pkg::OFS_CMP_B;
      localparam int FBIT = (ch == 0) ? tocu_pkg::FLAG_MATCH_A : tocu_pkg::FLAG_MATCH_B;

      assign cmp_wr[ch] = wr_go && (addr_r == OFS);
      assign cmp_eq[ch] = (counter_value == compare_value_chan[ch]);
      // A match only counts on a timer clock that is not blocked
      assign match_hit[ch] = timer_tick && cmp_eq[ch] && !block_r;
      // Force works only outside the PWM modes
      assign force_hit[ch] = wr_go && (addr_r == tocu_pkg::OFS_FORCE) && hwdata[ch]
         && !pwm_mode;

      // Buffer register takes every CPU write
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            compare_buf[ch] <= tocu_pkg::RST_BYTE;
         end else if (cmp_wr[ch]) begin
            compare_buf[ch] <= hwdata[7:0];
         end
      end

      // Active compare: direct write, or copy at top when buffered
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            compare_value_chan[ch] <= tocu_pkg::RST_BYTE;
         end else if (cmp_wr[ch] && !pwm_mode) begin
            compare_value_chan[ch] <= hwdata[7:0];
         end else if (pwm_mode && timer_tick && at_max) begin
            // Copy at top so no odd-length pulse appears
            compare_value_chan[ch] <= compare_buf[ch];
         end
      end

      // Compare flag; a match beats a clear in the same cycle
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            match_flag_chan[ch] <= 1'b0;
         end else if (match_hit[ch]) begin
            match_flag_chan[ch] <= 1'b1;
         end else if (flag_w1c[FBIT] || irq_ack[FBIT]) begin
            match_flag_chan[ch] <= 1'b0;
         end
      end

      // Output register; mode changes leave it untouched
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            wave_output_state[ch] <= tocu_pkg::RST_WAVE;
         end else if (match_hit[ch] || force_hit[ch]) begin
            // Match wins over bottom, so a compare at max gives a flat output
            unique case (output_action_sel[ch])
               tocu_pkg::ACT_NONE: wave_output_state[ch] <= wave_output_state[ch];
               tocu_pkg::ACT_TOGGLE: wave_output_state[ch] <= !wave_output_state[ch];
               tocu_pkg::ACT_CLEAR: wave_output_state[ch] <= 1'b0;
               tocu_pkg::ACT_SET: wave_output_state[ch] <= 1'b1;
            endcase
         end else if (pwm_mode && timer_tick && at_max) begin
            // Restore the PWM level as the counter passes to bottom
            if (output_action_sel[ch] == tocu_pkg::ACT_CLEAR) begin
               wave_output_state[ch] <= 1'b1;
            end else if (output_action_sel[ch] == tocu_pkg::ACT_SET) begin
               wave_output_state[ch] <= 1'b0;
            end
         end
      end

      // Pin drive; direction always belongs to the port
      always_ff @(posedge clk_sys or negedge rst_n) begin
         if (!rst_n) begin
            pin_o[ch] <= 1'b0;
            pin_oe[ch] <= 1'b0;
         end else begin
            pin_o[ch] <= (output_action_sel[ch] != tocu_pkg::ACT_NONE) ?
               wave_output_state[ch] : port_value[ch];
            pin_oe[ch] <= wave_pin_direction_bit[ch];
         end
      end
   end

   // Interrupt requests from enabled flags
   assign irq_req[tocu_pkg::FLAG_OVF] = overflow_flag && irq_en_r[tocu_pkg::FLAG_OVF];
   assign irq_req[tocu_pkg::FLAG_MATCH_A] = match_flag_chan[0]
      && irq_en_r[tocu_pkg::FLAG_MATCH_A];
   assign irq_req[tocu_pkg::FLAG_MATCH_B] = match_flag_chan[1]
      && irq_en_r[tocu_pkg::FLAG_MATCH_B];

   // Checks on the behaviour above
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_cnt_write;
      cnt_wr;
   endsequence
   sequence s_blocked_tick;
      block_r && timer_tick && !match_flag_chan[0];
   endsequence

   property p_flag_next;
      timer_tick && cmp_eq[0] && !block_r |=> match_flag_chan[0];
   endproperty
   a_flag_next: assert property (p_flag_next) else $error("match flag not set");

   property p_w1c;
      flag_w1c[tocu_pkg::FLAG_MATCH_A] && !match_hit[0] |=> !match_flag_chan[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag clear failed");

   property p_set_wins;
      match_hit[1] && (flag_w1c[tocu_pkg::FLAG_MATCH_B] || irq_ack[tocu_pkg::FLAG_MATCH_B])
         |=> match_flag_chan[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

   property p_block;
      s_cnt_write ##1 s_blocked_tick |=> !match_flag_chan[0];
   endproperty
   a_block: assert property (p_block) else $error("match not blocked");

   property p_cnt_write;
      cnt_wr |=> counter_value == $past(hwdata[7:0]);
   endproperty
   a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

   property p_wrap;
      timer_tick && at_max && !cnt_wr |=> at_bottom && overflow_flag;
   endproperty
   a_wrap: assert property (p_wrap) else $error("wrap or overflow wrong");

   property p_buffered;
      pwm_mode && cmp_wr[0] && !(timer_tick && at_max)
         |=> $stable(compare_value_chan[0]);
   endproperty
   a_buffered: assert property (p_buffered) else $error("buffer bypassed");

   property p_copy_top;
      pwm_mode && timer_tick && at_max |=> compare_value_chan[0] == $past(compare_buf[0]);
   endproperty
   a_copy_top: assert property (p_copy_top) else $error("buffer not copied");

   property p_force;
      force_hit[0] && output_action_sel[0] == tocu_pkg::ACT_TOGGLE && !match_flag_chan[0]
         && !match_hit[0] |=> wave_output_state[0] != $past(wave_output_state[0])
         && !match_flag_chan[0];
   endproperty
   a_force: assert property (p_force) else $error("force action wrong");

   property p_sel_none;
      output_action_sel[1] == tocu_pkg::ACT_NONE |=> $stable(wave_output_state[1]);
   endproperty
   a_sel_none: assert property (p_sel_none) else $error("output moved with no action");

   property p_override;
      output_action_sel[0] != tocu_pkg::ACT_NONE ##1 $stable(output_action_sel[0])
         |=> pin_o[0] == $past(wave_output_state[0], 1);
   endproperty
   a_override: assert property (p_override) else $error("pin not overridden");

   property p_strobe_zero;
      bus_r == tocu_pkg::TOCU_BUS_RD_WAIT && addr_r == tocu_pkg::OFS_FORCE |=> hrdata == 32'h0;
   endproperty
   a_strobe_zero: assert property (p_strobe_zero) else $error("strobe read nonzero");
endmodule : tocu_top

// ==== testbench/tocu_host_model.sv ====
// Interrupt servicing side of the host, answering requests after a short delay
module tocu_host_model (
   input wire logic clk_sys, // System clock
   input wire logic [2:0] irq_req, // Requests from the unit
   output logic [2:0] irq_ack // Service pulses back to the unit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_r; // Service latency counter
   initial begin
      irq_ack = 3'h0;
      wait_r = 2'h0;
   end
   // Services all pending requests once one has waited four cycles; later arrivals can be served sooner
   always @(posedge clk_sys) begin
      if (irq_ack !== 3'h0) begin
         irq_ack <= 3'h0; // Service lasts one cycle
      end else if (irq_req !== 3'h0) begin
         if (wait_r == 2'h3) begin
            irq_ack <= irq_req; // Acknowledge what is pending
            wait_r <= 2'h0;
         end else begin
            wait_r <= wait_r + 2'h1;
         end
      end else begin
         wait_r <= 2'h0;
      end
   end
endmodule : tocu_host_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the timer output compare unit
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0, nrst = 1'b0, timer_tick = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0, port_value = 2'h0, wave_pin_direction_bit = 2'h0;
   logic [1:0] pin_o, pin_oe;
   logic [2:0] irq_req, irq_ack;
   logic hreadyout, hresp;
   wire logic hready = hreadyout; // Single slave drives bus ready
   int bad_count = 0, checks = 0;
   int i;
   logic [1:0] acts [3] = '{tocu_pkg::ACT_SET, tocu_pkg::ACT_CLEAR, tocu_pkg::ACT_TOGGLE};
   logic [31:0] waves [3] = '{32'h1, 32'h0, 32'h1};
   always #20 clk_sys = ~clk_sys; // 25 MHz
   tocu_top dut (.clk_sys(clk_sys), .nrst(nrst), .timer_tick(timer_tick), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .irq_req(irq_req), .irq_ack(irq_ack), .port_value(port_value),
      .wave_pin_direction_bit(wave_pin_direction_bit), .pin_o(pin_o), .pin_oe(pin_oe));
   tocu_host_model host (.clk_sys(clk_sys), .irq_req(irq_req), .irq_ack(irq_ack));
   // One bus transfer; holds each phase until ready is seen at an edge
   task automatic bus_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= tocu_pkg::HTRANS_NONSEQ;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus_xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_xfer(1'b1, a, d, q);
   endtask : wr
   // Register read compared with its expected word
   task automatic check_reg(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus_xfer(1'b0, a, 32'h0, q);
      checks++;
      if (q !== e) begin
         bad_count++;
         $display("unexpected at %0t: reg %h got %h expected %h", $time, a, q, e);
      end
   endtask : check_reg
   // Pin level compared with its expected pair
   task automatic check_pin(input logic [1:0] g, input logic [1:0] e);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: pins got %h expected %h", $time, g, e);
      end
   endtask : check_pin
   // Interrupt request lines compared with their expected set
   task automatic check_irq(input logic [2:0] e);
      checks++;
      if (irq_req !== e) begin
         bad_count++;
         $display("unexpected at %0t: irq got %h expected %h", $time, irq_req, e);
      end
   endtask : check_irq
   // Back-to-back timer clocks, then one idle cycle
   task automatic ticks(input int n);
      timer_tick <= 1'b1;
      repeat (n) @(posedge clk_sys);
      timer_tick <= 1'b0;
      @(posedge clk_sys);
   endtask : ticks
   task automatic test_done;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   // Hang guard, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      test_done;
   end
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check_reg(tocu_pkg::OFS_STATUS, 32'h4); // Bottom seen, waves cleared
      check_reg(tocu_pkg::OFS_CTRL, 32'h0); // Selects start at zero
      check_reg(8'h20, 32'h0); // Unmapped offset reads zero like strobes
      // Set, clear and toggle applied through the force strobe in normal mode
      for (i = 0; i < 3; i++) begin
         wr(tocu_pkg::OFS_CTRL, 32'(acts[i]) << tocu_pkg::CTRL_SEL_A_LSB);
         wr(tocu_pkg::OFS_FORCE, 32'h1);
         check_reg(tocu_pkg::OFS_STATUS, 32'h4 | waves[i]); // Immediate action
         check_reg(tocu_pkg::OFS_FLAGS, 32'h0); // Force sets no flag
      end
      check_reg(tocu_pkg::OFS_FORCE, 32'h0); // Strobes keep nothing
      check_reg(tocu_pkg::OFS_COUNT, 32'h0); // Force leaves counter alone
      // Port override: A owned by the unit, B by the port
      port_value <= 2'b10;
      wave_pin_direction_bit <= 2'b11; // Wave state set up before direction
      repeat (2) @(posedge clk_sys);
      check_pin(pin_o, 2'b11); // Wave A overrides, B keeps port
      check_pin(pin_oe, 2'b11); // Direction from port bits
      wave_pin_direction_bit <= 2'b01;
      repeat (2) @(posedge clk_sys);
      check_pin(pin_oe, 2'b01); // Direction untouched by select
      // Counter write equal to compare loses that match
      wr(tocu_pkg::OFS_CMP_A, 32'h5);
      wr(tocu_pkg::OFS_COUNT, 32'h5);
      ticks(1);
      check_reg(tocu_pkg::OFS_FLAGS, 32'h0); // Match blocked after write
      wr(tocu_pkg::OFS_COUNT, 32'h4); // Counter kept off the compare value
      ticks(2);
      check_reg(tocu_pkg::OFS_FLAGS, 32'h2); // Match at 5 sets flag A
      check_reg(tocu_pkg::OFS_STATUS, 32'h0); // Toggle on match
      check_reg(tocu_pkg::OFS_COUNT, 32'h6); // Plain up count, two ticks
      wr(tocu_pkg::OFS_FLAGS, 32'h0);
      check_reg(tocu_pkg::OFS_FLAGS, 32'h2); // Zero write ignored
      wr(tocu_pkg::OFS_FLAGS, 32'h2);
      check_reg(tocu_pkg::OFS_FLAGS, 32'h0); // One write clears
      // Wrap with overflow serviced by the host; B matches at zero with no action
      wr(tocu_pkg::OFS_IRQ_EN, 32'h1);
      wr(tocu_pkg::OFS_COUNT, 32'hFF);
      check_reg(tocu_pkg::OFS_STATUS, 32'h8); // Max seen at FF
      ticks(2);
      check_irq(3'h1); // Enabled overflow requests service
      repeat (10) @(posedge clk_sys);
      check_irq(3'h0); // Service cleared the request
      check_reg(tocu_pkg::OFS_FLAGS, 32'h4); // Overflow serviced, B flagged
      check_reg(tocu_pkg::OFS_STATUS, 32'h0); // Select zero leaves wave B
      wr(tocu_pkg::OFS_FLAGS, 32'h7);
      wr(tocu_pkg::OFS_IRQ_EN, 32'h0);
      // Mode change keeps wave state; force refused in PWM
      wr(tocu_pkg::OFS_CTRL, 32'(tocu_pkg::ACT_SET) << tocu_pkg::CTRL_SEL_A_LSB);
      wr(tocu_pkg::OFS_FORCE, 32'h1);
      wr(tocu_pkg::OFS_CTRL, 32'h1 | (32'(tocu_pkg::ACT_CLEAR) << tocu_pkg::CTRL_SEL_A_LSB));
      check_reg(tocu_pkg::OFS_STATUS, 32'h1); // Wave kept across modes
      wr(tocu_pkg::OFS_FORCE, 32'h1);
      check_reg(tocu_pkg::OFS_STATUS, 32'h1); // No force in PWM
      // Buffered compare: old active value still matches
      wr(tocu_pkg::OFS_CMP_A, 32'h10);
      check_reg(tocu_pkg::OFS_CMP_A, 32'h10); // Buffer seen in PWM
      wr(tocu_pkg::OFS_COUNT, 32'h4);
      ticks(2);
      check_reg(tocu_pkg::OFS_STATUS, 32'h0); // Active still 5
      check_reg(tocu_pkg::OFS_FLAGS, 32'h2); // Match A flagged
      wr(tocu_pkg::OFS_CTRL, 32'(tocu_pkg::ACT_CLEAR) << tocu_pkg::CTRL_SEL_A_LSB);
      check_reg(tocu_pkg::OFS_CMP_A, 32'h5); // Active seen when unbuffered
      // Copy at top, then new value matches
      wr(tocu_pkg::OFS_CTRL, 32'h1 | (32'(tocu_pkg::ACT_CLEAR) << tocu_pkg::CTRL_SEL_A_LSB));
      wr(tocu_pkg::OFS_FLAGS, 32'h7);
      wr(tocu_pkg::OFS_COUNT, 32'hFE);
      ticks(2);
      check_reg(tocu_pkg::OFS_STATUS, 32'h5); // Set at wrap in PWM
      wr(tocu_pkg::OFS_COUNT, 32'h0F);
      ticks(2);
      check_reg(tocu_pkg::OFS_FLAGS, 32'h3); // Copied value matches at 10
      check_reg(tocu_pkg::OFS_STATUS, 32'h0); // Cleared on match
      // Wave B raised by force, then a B match with select zero must keep it
      wr(tocu_pkg::OFS_CTRL, 32'(tocu_pkg::ACT_SET) << tocu_pkg::CTRL_SEL_B_LSB);
      wr(tocu_pkg::OFS_FORCE, 32'h2);
      wr(tocu_pkg::OFS_CTRL, 32'h0);
      wr(tocu_pkg::OFS_COUNT, 32'hFF);
      ticks(2);
      check_reg(tocu_pkg::OFS_STATUS, 32'h2); // Wave B held through match
      check_reg(tocu_pkg::OFS_FLAGS, 32'h7); // B match and wrap flagged
      check_pin(pin_o, 2'b10); // Zero selects hand pins to port
      test_done;
   end
endmodule : testbench
